// file: common/rvr_pkg.sv
/*
 * Constants and carrier types for the restart vector redirect block.
 * Assumes a single bus clock and a processor that issues the reset control code on its memory-control bus.
 */
package rvr_pkg;
    localparam logic [4:0] RESET_CODE = 5'h08;
    localparam logic [7:0] RESET_DATA = 8'h00;
    localparam logic [7:0] REDIRECT_DATA = 8'h80;
    localparam logic [15:0] MONITOR_ENTRY = 16'h8080;
    localparam logic [15:0] USER_ENTRY = 16'h0000;
    localparam logic [1:0] POS_USER = 2'h0;
    localparam logic [1:0] POS_KEYPAD = 2'h1;
    localparam logic [1:0] POS_TERMINAL = 2'h2;

    typedef struct packed {
        logic [4:0] memory_control_code;
        logic bus_drive_direction;
        logic [1:0] execution_source_switch;
    } rvr_ctrl_t;
endpackage

// file: hdl/rvr_redirect.sv
/*
 * Steering of the top data bit during the reset bus cycle.
 * Assumes control inputs arrive from pins and are synchronised here; the pull-up is modelled as a driven high.
 */
`timescale 1ns/1ps
module rvr_redirect (
    input wire logic clk,
    input wire logic resetn,
    input wire rvr_pkg::rvr_ctrl_t ctrl_in,
    input wire logic processor_msb_line_in,
    input wire logic gated_msb_line_in,
    output logic processor_msb_line_out,
    output logic processor_msb_line_oen,
    output logic gated_msb_line_out,
    output logic gated_msb_line_oen,
    output logic isolate_enable
);
    // Settled copies of the pin inputs; nothing here reads a first stage.
    rvr_pkg::rvr_ctrl_t ctrl_s2;
    logic [4:0] code_s3;
    logic cpu_s2;
    logic gated_s2;

    // Decoded view of the settled control inputs.
    logic reset_code_seen;
    logic non_user_position;
    logic redirect;

    // Pin levels pass two flops before any logic reads them.
    rvr_sync #(
        .WIDTH($bits(rvr_pkg::rvr_ctrl_t))
    ) ctrl_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(ctrl_in),
        .synced(ctrl_s2)
    );

    rvr_sync #(
        .WIDTH(1)
    ) cpu_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(processor_msb_line_in),
        .synced(cpu_s2)
    );

    rvr_sync #(
        .WIDTH(1)
    ) gated_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(gated_msb_line_in),
        .synced(gated_s2)
    );

    // code held check.
    // The code bits settle one by one, so a code in transit can read as a mix for a cycle.
    // Acting only on a code seen twice in a row costs one cycle and keeps a mix from faking a restart.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code_s3 <= 5'h00;
        end else begin
            code_s3 <= ctrl_s2.memory_control_code;
        end
    end

    always_comb begin
        reset_code_seen = (ctrl_s2.memory_control_code == rvr_pkg::RESET_CODE)
            && (code_s3 == rvr_pkg::RESET_CODE);
        non_user_position = (ctrl_s2.execution_source_switch != rvr_pkg::POS_USER);
        redirect = reset_code_seen && non_user_position;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            isolate_enable <= 1'b0;
        end else begin
            isolate_enable <= redirect;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            gated_msb_line_out <= 1'b0;
            gated_msb_line_oen <= 1'b1;
        end else if (redirect) begin
            // Stands in for the pull-up, so the devices load the monitor entry and not zero.
            gated_msb_line_out <= rvr_pkg::REDIRECT_DATA[7];
            gated_msb_line_oen <= 1'b0;
        end else if (ctrl_s2.bus_drive_direction) begin
            gated_msb_line_out <= cpu_s2;
            gated_msb_line_oen <= 1'b0;
        end else begin
            gated_msb_line_out <= 1'b0;
            gated_msb_line_oen <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            processor_msb_line_out <= 1'b0;
            processor_msb_line_oen <= 1'b1;
        end else if (redirect) begin
            processor_msb_line_out <= 1'b0;
            processor_msb_line_oen <= 1'b1;
        end else if (!ctrl_s2.bus_drive_direction) begin
            processor_msb_line_out <= gated_s2;
            processor_msb_line_oen <= 1'b0;
        end else begin
            processor_msb_line_out <= 1'b0;
            processor_msb_line_oen <= 1'b1;
        end
    end

    // A reset code in a non-user position isolates the processor next cycle.
    AST_ISOLATE: assert property (@(posedge clk) disable iff (!resetn)
        redirect
        |=> isolate_enable && processor_msb_line_oen)
        else $error("isolation missing");

    AST_KEYPAD: assert property (@(posedge clk) disable iff (!resetn)
        (reset_code_seen && ctrl_s2.execution_source_switch == rvr_pkg::POS_KEYPAD)
        |=> isolate_enable)
        else $error("keypad position not isolating");

    AST_TERMINAL: assert property (@(posedge clk) disable iff (!resetn)
        (reset_code_seen && ctrl_s2.execution_source_switch == rvr_pkg::POS_TERMINAL)
        |=> isolate_enable)
        else $error("terminal position not isolating");

    AST_HELD_CODE: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl_s2.memory_control_code == rvr_pkg::RESET_CODE && code_s3 != rvr_pkg::RESET_CODE)
        |=> !isolate_enable)
        else $error("isolation on an unconfirmed code");

    // Once the reset code leaves the bus the isolation ends on the next edge.
    AST_RELEASE: assert property (@(posedge clk) disable iff (!resetn)
        (isolate_enable && ctrl_s2.memory_control_code != rvr_pkg::RESET_CODE)
        |=> !isolate_enable)
        else $error("isolation outlived the reset code");

    AST_PULLUP: assert property (@(posedge clk) disable iff (!resetn)
        redirect
        |=> gated_msb_line_out && !gated_msb_line_oen)
        else $error("gated line not high");

    AST_USER: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl_s2.execution_source_switch == rvr_pkg::POS_USER)
        |=> !isolate_enable)
        else $error("redirect in user position");

    AST_USER_PASS: assert property (@(posedge clk) disable iff (!resetn)
        (reset_code_seen && ctrl_s2.execution_source_switch == rvr_pkg::POS_USER && ctrl_s2.bus_drive_direction)
        |=> !gated_msb_line_oen && gated_msb_line_out == $past(cpu_s2))
        else $error("user position reset bit not passed");

    AST_ONE_DIR: assert property (@(posedge clk) disable iff (!resetn)
        ($past(resetn) && !$past(redirect))
        |-> (gated_msb_line_oen != processor_msb_line_oen))
        else $error("both or no buffers enabled");

    AST_OUT_DIR: assert property (@(posedge clk) disable iff (!resetn)
        (!redirect && ctrl_s2.bus_drive_direction)
        |=> !gated_msb_line_oen && processor_msb_line_oen)
        else $error("outbound direction not selected");

    AST_IN_DIR: assert property (@(posedge clk) disable iff (!resetn)
        (!redirect && !ctrl_s2.bus_drive_direction)
        |=> gated_msb_line_oen && !processor_msb_line_oen)
        else $error("inbound direction not selected");

    AST_FOLLOW_OUT: assert property (@(posedge clk) disable iff (!resetn)
        (!redirect && ctrl_s2.bus_drive_direction)
        |=> gated_msb_line_out == $past(cpu_s2))
        else $error("gated line not following");

    AST_FOLLOW_IN: assert property (@(posedge clk) disable iff (!resetn)
        (!redirect && !ctrl_s2.bus_drive_direction)
        |=> processor_msb_line_out == $past(gated_s2))
        else $error("inbound bit not following");

    AST_CODE_ONLY: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl_s2.memory_control_code != rvr_pkg::RESET_CODE)
        |=> !isolate_enable)
        else $error("isolation without the reset code");

    AST_OTHER_OUT: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl_s2.memory_control_code != rvr_pkg::RESET_CODE && ctrl_s2.bus_drive_direction)
        |=> !gated_msb_line_oen && gated_msb_line_out == $past(cpu_s2))
        else $error("other code outbound bit not passed");

    AST_OTHER_IN: assert property (@(posedge clk) disable iff (!resetn)
        (ctrl_s2.memory_control_code != rvr_pkg::RESET_CODE && !ctrl_s2.bus_drive_direction)
        |=> !processor_msb_line_oen && processor_msb_line_out == $past(gated_s2))
        else $error("other code inbound bit not passed");
endmodule

// Two-flop synchroniser for pin levels; only the second stage leaves the module.
module rvr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= pin;
            synced <= stage1;
        end
    end
endmodule

// file: verification/rvr_bus.sv
/* Far-side model of the processor and bus devices. Assumes the bench sets bit 7 and the direction. */
`timescale 1ns/1ps
module rvr_bus (
    input wire logic clk,
    input wire rvr_pkg::rvr_ctrl_t c,
    input wire logic b,
    input wire logic [3:0] d,
    output logic [1:0] w,
    output logic [15:0] pc
);
    assign w[1] = c.bus_drive_direction ? b & (c.memory_control_code != rvr_pkg::RESET_CODE) : (d[2] ? !b : d[3]);
    assign w[0] = d[0] ? b ^ c.bus_drive_direction : d[1];
    always_ff @(posedge clk) if (c.memory_control_code == rvr_pkg::RESET_CODE) pc <= {w[0], 7'h00, w[0], 7'h00};
endmodule

// file: verification/tb.sv
/* Bench for the redirect block. Assumes the bus model stands at the far side. */
`timescale 1ns/1ps
module tb;
    logic clk = 1'h0, resetn = 1'h0, b = 1'h0, po, pn, go, gn, iso;
    logic [1:0] w;
    logic [15:0] pc;
    rvr_pkg::rvr_ctrl_t c = '0;
    int err_count = 0, checks_done = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    rvr_redirect dut (.clk(clk), .resetn(resetn), .ctrl_in(c), .processor_msb_line_in(w[1]), .gated_msb_line_in(w[0]),
        .processor_msb_line_out(po), .processor_msb_line_oen(pn), .gated_msb_line_out(go),
        .gated_msb_line_oen(gn), .isolate_enable(iso));
    rvr_bus bus (.clk(clk), .c(c), .b(b), .d({po, pn, go, gn}), .w(w), .pc(pc));
    task chk(input logic [15:0] got, exp);
        checks_done++;
        if (got !== exp) err_count++;
        if (got !== exp) $display("BAD %0t got %h want %h", $time, got, exp);
    endtask
    task t_rst(input logic [1:0] s);
        @(negedge clk);
        c = {rvr_pkg::RESET_CODE, 1'h1, s};
        repeat (6) @(negedge clk);
        chk(16'(iso), 16'(s != rvr_pkg::POS_USER));
        chk(16'({pn, gn}), 16'(2'h2));
        chk(pc, s == rvr_pkg::POS_USER ? rvr_pkg::USER_ENTRY : rvr_pkg::MONITOR_ENTRY);
    endtask
    task t_reset;
        @(negedge clk);
        resetn = 1'h0;
        repeat (3) @(negedge clk);
        chk(16'({po, pn, go, gn, iso}), 16'(5'h0a));
        resetn = 1'h1;
    endtask
    task t_pass(input logic dr, input logic v, input logic [1:0] s);
        @(negedge clk);
        c = {5'h03, dr, s};
        b = v;
        repeat (6) @(negedge clk);
        chk(16'(dr ? w[0] : w[1]), 16'(v));
        chk(16'({pn, gn, iso}), 16'({dr, !dr, 1'h0}));
    endtask
    task end_sim(input int extra);
        err_count += extra;
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'h1;
        for (int s = 0; s < 4; s++) t_rst(2'(s));
        t_reset();
        for (int k = 0; k < 12; k++) t_pass(k[1], k[0], 2'(k / 4));
        end_sim(0);
    end
    // The scenarios need well under 200 cycles; a hang ends the run here.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) end_sim(1);
    end
endmodule
